//--- design/pirmap_defines.svh
// Constants of the peripheral input remap block: register offsets,
// field positions, reset values and selection codes.
// Assumes inclusion by the package and the top module only.
//
// Functional notes
// - Seven-bit fields; zero selects ground.
// - Code one selects comparator one output.
// - Top code selects pin 121; above undefined.
// - Non-field bits read zero, ignore writes.
// - All fields clear at power-on reset.
// - Field bits read back last written value.
// - Interrupt one selector in bits 14..8.
// - Interrupt two selector in bits 6..0.
// - Timer two clock selector in bits 6..0.
// - Capture two high, capture one low.
// - Capture four high, capture three low.
// - Compare fault A selector in bits 6..0.
// - PWM fault two high, one low.
// - Encoder phase B high, A low.
// - Encoder home high, index low.
// - UART one receive selector, low bits.
// - UART two receive selector, separate register.
// - SPI two clock high, data low.
`ifndef PIRMAP_DEFINES_SVH
`define PIRMAP_DEFINES_SVH

`define PIRMAP_SEL_W 7
`define PIRMAP_HI_LSB 8
`define PIRMAP_LO_LSB 0
`define PIRMAP_REG_RESET 16'h0000
`define PIRMAP_SEL_GROUND 7'h00
`define PIRMAP_SEL_COMPARATOR_ONE_OUTPUT 7'h01
`define PIRMAP_SEL_MAX 7'h79
`define PIRMAP_PIN_COUNT 128
`define PIRMAP_PIN_BASE 7'h02
`define PIRMAP_NREGS 12

`define PIRMAP_OFF_IRQ1 12'h000
`define PIRMAP_OFF_IRQ2 12'h004
`define PIRMAP_OFF_TMR2 12'h008
`define PIRMAP_OFF_CAP12 12'h00C
`define PIRMAP_OFF_CAP34 12'h010
`define PIRMAP_OFF_CFLT 12'h014
`define PIRMAP_OFF_PFLT 12'h018
`define PIRMAP_OFF_QPH 12'h01C
`define PIRMAP_OFF_QHI 12'h020
`define PIRMAP_OFF_UART_ONE_RECEIVE 12'h024
`define PIRMAP_OFF_UART_TWO_RECEIVE 12'h028
`define PIRMAP_OFF_SPI2 12'h02C

// Implemented-bit masks per register index
`define PIRMAP_MASK_HI 16'h7F00
`define PIRMAP_MASK_LO 16'h007F
`define PIRMAP_MASK_BOTH 16'h7F7F

`endif

//--- design/pirmap_pkg.sv
// Types of the peripheral input remap block.
// Assumes the defines header is on the include path.
`include "pirmap_defines.svh"

package pirmap_pkg;

  typedef logic [`PIRMAP_SEL_W-1:0] pirmap_sel_t;

  // Routed peripheral inputs, one bit each
  typedef struct packed {
    logic ext_irq_one;
    logic ext_irq_two;
    logic timer_two_ext_clock;
    logic capture_one;
    logic capture_two;
    logic capture_three;
    logic capture_four;
    logic compare_fault_a;
    logic pwm_fault_one;
    logic pwm_fault_two;
    logic encoder_phase_a;
    logic encoder_phase_b;
    logic encoder_home;
    logic encoder_index;
    logic uart_one_receive;
    logic uart_two_receive;
    logic spi_two_clock_in;
    logic spi_two_data_in;
  } pirmap_periph_in_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pirmap_apb_req_t;

endpackage : pirmap_pkg

//--- design/pirmap_top.sv
// Peripheral input remap: APB registers holding seven-bit source
// selectors, and the muxes that route pins or comparator one to inputs.
// Assumes pins and the comparator are asynchronous to pclk.
`timescale 1ns/1ns
`include "pirmap_defines.svh"

module pirmap_top
  import pirmap_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pirmap_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sources
  input wire logic [`PIRMAP_PIN_COUNT-1:0] remap_input_pin,
  input wire logic comparator_one_output,
  // Routed peripheral inputs
  output pirmap_periph_in_t periph_in
);

  ////////////////////////////////////////////////////////////////////
  // Register file: one 16-bit word per index, unused bits held zero

  localparam logic [15:0] IMPL_MASK [`PIRMAP_NREGS] = '{
    `PIRMAP_MASK_HI, `PIRMAP_MASK_LO, `PIRMAP_MASK_LO,
    `PIRMAP_MASK_BOTH, `PIRMAP_MASK_BOTH, `PIRMAP_MASK_LO,
    `PIRMAP_MASK_BOTH, `PIRMAP_MASK_BOTH, `PIRMAP_MASK_BOTH,
    `PIRMAP_MASK_LO, `PIRMAP_MASK_LO, `PIRMAP_MASK_BOTH};

  logic [15:0] sel_reg [`PIRMAP_NREGS];
  logic [3:0] reg_idx;
  logic addr_hit;
  logic access;

  always_comb begin
    reg_idx = apb_req.paddr[5:2];
    addr_hit = (apb_req.paddr[1:0] == 2'h0) &&
               (apb_req.paddr[11:6] == 6'h00) &&
               (reg_idx < 4'(`PIRMAP_NREGS));
    access = apb_req.psel && apb_req.penable && pready;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PIRMAP_NREGS; gi++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_reg[gi] <= `PIRMAP_REG_RESET;
        end else if (access && apb_req.pwrite && addr_hit &&
                     reg_idx == 4'(gi)) begin
          // Masked store keeps unused bits at zero
          sel_reg[gi] <= apb_req.pwdata[15:0] & IMPL_MASK[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, so read data comes from a flop

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_req.psel && apb_req.penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_req.psel && apb_req.penable && !pready) begin
      prdata <= (addr_hit && !apb_req.pwrite) ?
                {16'h0000, sel_reg[reg_idx]} : 32'h0000_0000;
      pslverr <= !addr_hit;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Source synchronisers; first stage read by the second only

  logic [`PIRMAP_PIN_COUNT:0] src_meta;
  logic [`PIRMAP_PIN_COUNT:0] src_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= {remap_input_pin, comparator_one_output};
      src_sync <= src_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Code decode: 0 ground, 1 comparator, 2..121 pin (code),
  // undefined codes give ground

  function automatic logic route(input logic [6:0] code,
                                 input logic [`PIRMAP_PIN_COUNT:0] src);
    logic r;
    r = 1'b0;
    if (code == `PIRMAP_SEL_GROUND) begin
      r = 1'b0;
    end else if (code == `PIRMAP_SEL_COMPARATOR_ONE_OUTPUT) begin
      r = src[0];
    end else if (code <= `PIRMAP_SEL_MAX) begin
      // Pin table: code n selects remap input pin n
      r = src[code + 8'h01];
    end
    return r;
  endfunction : route

  localparam int NSEL = 18;
  // Per routed input: register index and field lsb
  localparam int SEL_REG [NSEL] = '{
    0, 1, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 8, 8, 9, 10, 11, 11};
  localparam int SEL_LSB [NSEL] = '{
    `PIRMAP_HI_LSB, `PIRMAP_LO_LSB, `PIRMAP_LO_LSB,
    `PIRMAP_LO_LSB, `PIRMAP_HI_LSB, `PIRMAP_LO_LSB, `PIRMAP_HI_LSB,
    `PIRMAP_LO_LSB, `PIRMAP_LO_LSB, `PIRMAP_HI_LSB,
    `PIRMAP_LO_LSB, `PIRMAP_HI_LSB, `PIRMAP_HI_LSB, `PIRMAP_LO_LSB,
    `PIRMAP_LO_LSB, `PIRMAP_LO_LSB, `PIRMAP_HI_LSB, `PIRMAP_LO_LSB};

  // Field placement
  logic [NSEL-1:0] routed;

  generate
    for (gi = 0; gi < NSEL; gi++) begin : g_route
      // Live follow of field value, no enable step
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          routed[NSEL-1-gi] <= 1'b0;
        end else begin
          routed[NSEL-1-gi] <= route(
            sel_reg[SEL_REG[gi]][SEL_LSB[gi] +: `PIRMAP_SEL_W],
            src_sync);
        end
      end
    end
  endgenerate

  assign periph_in = routed;

endmodule : pirmap_top

//--- verification/pirmap_checker.sv
// Checker for the remap block, sees only top ports.
// Assumes bind into pirmap_top and one clock domain.
`timescale 1ns/1ns
module pirmap_checker
  import pirmap_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pirmap_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comparator_one_output,
  input wire pirmap_periph_in_t periph_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; $rose(apb_req.penable) && apb_req.psel |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("late pready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  property p_unused; pready && !apb_req.pwrite
    |-> prdata[31:15] == 17'h0 && !prdata[7]; endproperty
  a_unused: assert property (p_unused) else $error("bits");
  property p_err; pready && apb_req.paddr >= 12'h030 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; pready && apb_req.paddr < 12'h030
    && apb_req.paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("bad error");
  property p_rst; $rose(presetn) |-> periph_in == '0; endproperty
  a_rst: assert property (p_rst) else $error("not ground");
  property p_gnd; pready && apb_req.pwrite && apb_req.paddr == 12'h004
    && apb_req.pwdata[6:0] == 7'h00 |=> ##1 !periph_in.ext_irq_two[*2];
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground");
  property p_cmp; pready && apb_req.pwrite && apb_req.paddr == 12'h004
    && apb_req.pwdata[6:0] == 7'h01 |-> ##4
    periph_in.ext_irq_two == $past(comparator_one_output, 3); endproperty
  a_cmp: assert property (p_cmp) else $error("cmp route");
endmodule : pirmap_checker
bind pirmap_top pirmap_checker u_chk (.pclk, .presetn, .apb_req, .prdata,
  .pready, .pslverr, .comparator_one_output, .periph_in);

//--- verification/pirmap_src_model.sv
// Pins and comparator one, launched from pclk.
// Assumes the bench sets the wanted levels.
`timescale 1ns/1ns
module pirmap_src_model (
  input wire logic pclk,
  input wire logic [127:0] pins_set,
  input wire logic cmp_set,
  output logic [127:0] pins,
  output logic cmp
);
  always_ff @(posedge pclk) begin
    pins <= pins_set;
    cmp <= cmp_set;
  end
endmodule : pirmap_src_model

//--- verification/pirmap_top_tb.sv
// Bench for the remap block: APB access and routing.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ns
module pirmap_top_tb;
  import pirmap_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  pirmap_apb_req_t req = '0;
  logic [31:0] prdata, r, s;
  logic pready, pslverr, e, cmp, cmp_set = 1'b0;
  logic [127:0] pins, pins_set = '0;
  pirmap_periph_in_t pin_out;
  int mismatches = 0, n_checks = 0;
  logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h02, 7'h40, 7'h79, 7'h7F};
  // Last value written per register, kept to build the expected routing
  logic [15:0] wv [12];
  // Per routed input, msb first: register index and field lsb
  int fr [18] = '{0, 1, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 8, 8, 9, 10, 11, 11};
  int fl [18] = '{8, 0, 0, 0, 8, 0, 8, 0, 0, 8, 0, 8, 8, 0, 0, 0, 8, 0};
  always #5 pclk = ~pclk;
  pirmap_src_model src (.pclk(pclk), .pins_set(pins_set),
    .cmp_set(cmp_set), .pins(pins), .cmp(cmp));
  pirmap_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remap_input_pin(pins), .comparator_one_output(cmp),
    .periph_in(pin_out));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [15:0] msk(input int i);
    if (i == 0) return 16'h7F00;
    if (i inside {1, 2, 5, 9, 10}) return 16'h007F;
    return 16'h7F7F;
  endfunction : msk
  function automatic logic route(input logic [6:0] c);
    if (c == 7'h01) return cmp_set;
    if (c == 7'h00 || c > 7'h79) return 1'b0;
    return pins_set[c];
  endfunction : route
  function automatic logic [17:0] exp_all();
    logic [17:0] x;
    x = '0;
    for (int k = 0; k < 18; k++) begin
      x[17 - k] = route(wv[fr[k]][fl[k] +: 7]);
    end
    return x;
  endfunction : exp_all
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb
  initial begin
    s = 32'hE9D5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    for (int i = 0; i < 12; i++) begin
      s = xs(s);
      apb(1'b1, 12'(i * 4), s);
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(r, {16'h0, s[15:0] & msk(i)});
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, e}, 32'h1);
    foreach (codes[k]) for (int v = 0; v < 2; v++) begin
      s = xs(s);
      pins_set <= v ? ~{4{s}} : {4{s}};
      cmp_set <= s[v];
      apb(1'b1, 12'h004, {25'h0, codes[k]});
      repeat (6) @(posedge pclk);
      chk({31'h0, pin_out.ext_irq_two}, {31'h0, route(codes[k])});
    end
    // Every routed input at once, random codes in every field
    repeat (4) begin
      s = xs(s);
      pins_set <= {s, ~s, s ^ 32'h5A5A_A5A5, {s[15:0], s[31:16]}};
      cmp_set <= s[3];
      for (int i = 0; i < 12; i++) begin
        s = xs(s);
        wv[i] = s[15:0] & msk(i);
        apb(1'b1, 12'(i * 4), s);
      end
      repeat (6) @(posedge pclk);
      chk({14'h0, pin_out}, {14'h0, exp_all()});
    end
    summarize();
  end
endmodule : pirmap_top_tb
